// *** design/uart_line_params.svh ***
/*
  Register offsets, field positions, reset values and timing counts for the
  UART line format block. Definitions only; included by its bare name.
*/
`ifndef UART_LINE_PARAMS_SVH
`define UART_LINE_PARAMS_SVH

`define OFS_DIV_LOW 12'h000
`define OFS_DIV_HIGH 12'h004
`define OFS_ENH_FEAT 12'h008
`define OFS_LINE_FMT 12'h00c
`define OFS_MODEM_CTL 12'h010
`define OFS_LINE_STAT 12'h014
`define OFS_TX_DATA 12'h018

`define LFC_DLAB 7
`define LFC_BREAK 6
`define LFC_PAR_HI 5
`define LFC_PAR_LO 3
`define LFC_STOP 2
`define LFC_WLEN_HI 1
`define LFC_WLEN_LO 0
`define MLC_PRESCALE 7
`define MLC_IR_EN 6

`define RST_LINE_FMT 8'h00
`define RST_MODEM_CTL 8'h00
`define RST_ENH_FEAT 8'h00
`define RST_DIV 16'h0001

`define PRESCALE_LAST 2'h3
`define HALVES_PER_BIT 3'h2
`define HALVES_STOP_ONE 3'h2
`define HALVES_STOP_ONE_HALF 3'h3
`define HALVES_STOP_TWO 3'h4
`define WLEN_BASE 4'h5

`endif

// *** design/uart_line_pkg.sv ***
/*
  Shared types of the UART line format block.
  Assumes uart_line_params.svh supplies the numeric constants.
*/
package uart_line_pkg;
  typedef enum logic [2:0] {
    pm_none,
    pm_odd,
    pm_even,
    pm_one,
    pm_zero
  } parity_t;
  typedef enum logic [2:0] {
    tx_idle,
    tx_start,
    tx_data,
    tx_parity,
    tx_stop
  } tx_state_t;
endpackage

// *** design/char_tx.sv ***
/*
  Character serialiser working in half-bit steps, so that one and a half
  stop bits can be produced. Assumes half_tick is a one-cycle enable at twice
  the bit rate and that format inputs are stable while busy is high.
*/
`timescale 1ns/1ps
`include "uart_line_params.svh"
module char_tx (
  input wire logic clk,
  input wire logic rst,
  input wire logic half_tick,
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic [1:0] word_len,
  input wire logic stop_sel,
  input wire uart_line_pkg::parity_t parity_mode,
  input wire logic force_break,
  input wire logic ir_en,
  output logic tx_out_q,
  output logic ir_tx_q,
  output logic busy_q
);
  uart_line_pkg::tx_state_t state_q, state_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bits_q, bits_d;
  logic [2:0] half_q, half_d;
  logic par_q, par_d;
  logic tx_out_d, ir_tx_d, busy_d;
  logic line_bit;
  logic [3:0] nbits;
  logic [2:0] stop_halves;
  logic [7:0] masked;

  always_comb begin
    nbits = `WLEN_BASE + {2'h0, word_len};
    masked = data & ~(8'hff << nbits);
    if (!stop_sel) begin
      stop_halves = `HALVES_STOP_ONE;
    end else if (word_len == 2'h0) begin
      stop_halves = `HALVES_STOP_ONE_HALF;
    end else begin
      stop_halves = `HALVES_STOP_TWO;
    end
    state_d = state_q;
    shift_d = shift_q;
    bits_d = bits_q;
    half_d = half_q;
    par_d = par_q;
    case (state_q)
      uart_line_pkg::tx_idle: begin
        if (start) begin
          state_d = uart_line_pkg::tx_start;
          shift_d = masked;
          bits_d = nbits;
          half_d = 3'h0;
          case (parity_mode)
            uart_line_pkg::pm_odd: par_d = ~^masked;
            uart_line_pkg::pm_even: par_d = ^masked;
            uart_line_pkg::pm_one: par_d = 1'b1;
            default: par_d = 1'b0;
          endcase
        end
      end
      uart_line_pkg::tx_start: begin
        if (half_tick) begin
          half_d = half_q + 3'h1;
          if (half_q + 3'h1 == `HALVES_PER_BIT) begin
            half_d = 3'h0;
            state_d = uart_line_pkg::tx_data;
          end
        end
      end
      uart_line_pkg::tx_data: begin
        if (half_tick) begin
          half_d = half_q + 3'h1;
          if (half_q + 3'h1 == `HALVES_PER_BIT) begin
            half_d = 3'h0;
            shift_d = {1'b0, shift_q[7:1]};
            bits_d = bits_q - 4'h1;
            if (bits_q == 4'h1) begin
              state_d = (parity_mode == uart_line_pkg::pm_none) ?
                uart_line_pkg::tx_stop : uart_line_pkg::tx_parity;
            end
          end
        end
      end
      uart_line_pkg::tx_parity: begin
        if (half_tick) begin
          half_d = half_q + 3'h1;
          if (half_q + 3'h1 == `HALVES_PER_BIT) begin
            half_d = 3'h0;
            state_d = uart_line_pkg::tx_stop;
          end
        end
      end
      uart_line_pkg::tx_stop: begin
        if (half_tick) begin
          half_d = half_q + 3'h1;
          if (half_q + 3'h1 == stop_halves) begin
            half_d = 3'h0;
            state_d = uart_line_pkg::tx_idle;
          end
        end
      end
      default: state_d = uart_line_pkg::tx_idle;
    endcase
    case (state_q)
      uart_line_pkg::tx_start: line_bit = 1'b0;
      uart_line_pkg::tx_data: line_bit = shift_q[0];
      uart_line_pkg::tx_parity: line_bit = par_q;
      default: line_bit = 1'b1;
    endcase
    busy_d = (state_d != uart_line_pkg::tx_idle);
    // the standard output parks at mark while the infrared path is in use, except under break, which drives it low
    tx_out_d = force_break ? 1'b0 : (ir_en ? 1'b1 : line_bit);
    // half-bit pulse per zero bit: coarser than a 3/16 pulse, idles low
    ir_tx_d = ir_en && (force_break || !line_bit) && (half_q == 3'h0);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= uart_line_pkg::tx_idle;
      shift_q <= 8'h00;
      bits_q <= 4'h0;
      half_q <= 3'h0;
      par_q <= 1'b0;
      tx_out_q <= 1'b1;
      ir_tx_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bits_q <= bits_d;
      half_q <= half_d;
      par_q <= par_d;
      tx_out_q <= tx_out_d;
      ir_tx_q <= ir_tx_d;
      busy_q <= busy_d;
    end
  end
endmodule

// *** design/uart_line_format_control.sv ***
/*
  UART character format and line control with an APB register slave,
  divisor-based half-bit timing, prescaler, break and infrared routing.
  Every register is one aligned 32-bit word of which only the low byte is
  stored; the divisor latches and the enhanced register answer as zero
  while the latch access bit is clear.
  Assumes a synchronous APB master on clk and line inputs synchronous to clk.
  Assumes software leaves the line format alone while tx_busy_q is high,
  because stop length and parity are read live by the serialiser.
*/
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "uart_line_params.svh"
module uart_line_format_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  input wire logic rx_in,
  input wire logic ir_rx_in,
  output logic tx_out_q,
  output logic ir_tx_q,
  output logic rx_line_q,
  output logic tx_busy_q
);
  logic [7:0] lfc_q, lfc_d;
  logic [7:0] mlc_q, mlc_d;
  logic [7:0] enh_q, enh_d;
  logic [15:0] div_q, div_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic [1:0] pre_q, pre_d;
  logic [15:0] baud_q, baud_d;
  logic rx_line_d;
  logic tx_start_d, tx_start_q;
  logic [7:0] tx_byte_q, tx_byte_d;
  logic access, wr_ok, pre_tick, half_tick, dlab, known;
  logic [7:0] rdata;
  logic [15:0] div_last;
  logic [7:0] line_stat;
  // decoded once here so the serialiser and any later receiver agree on
  // the parity encoding
  uart_line_pkg::parity_t parity_mode;
  logic tx_out_w, ir_tx_w, busy_w;

  assign dlab = lfc_q[`LFC_DLAB];

  // parity decode; bit 3 clear always wins
  always_comb begin
    case (lfc_q[`LFC_PAR_HI:`LFC_PAR_LO])
      3'b001: parity_mode = uart_line_pkg::pm_odd;
      3'b011: parity_mode = uart_line_pkg::pm_even;
      3'b101: parity_mode = uart_line_pkg::pm_one;
      3'b111: parity_mode = uart_line_pkg::pm_zero;
      default: parity_mode = uart_line_pkg::pm_none;
    endcase
  end

  // apb: setup, then access; pready rises in the second access cycle
  always_comb begin
    access = psel && penable && !pready_q;
    line_stat = {4'h0, rx_line_q, ir_tx_q, tx_out_q, tx_busy_q};
    known = 1'b1;
    rdata = 8'h00;
    case (paddr)
      `OFS_DIV_LOW: rdata = dlab ? div_q[7:0] : 8'h00;
      `OFS_DIV_HIGH: rdata = dlab ? div_q[15:8] : 8'h00;
      `OFS_ENH_FEAT: rdata = dlab ? enh_q : 8'h00;
      `OFS_LINE_FMT: rdata = lfc_q;
      `OFS_MODEM_CTL: rdata = mlc_q;
      `OFS_LINE_STAT: rdata = line_stat;
      `OFS_TX_DATA: rdata = 8'h00;
      default: known = 1'b0;
    endcase
    pready_d = access;
    pslverr_d = access && !known;
    prdata_d = (access && !pwrite) ? {24'h000000, rdata} : 32'h00000000;
  end

  // register writes land at the edge that completes the transfer, so a
  // refused or unmapped access never touches state
  always_comb begin
    wr_ok = psel && penable && pready_q && pwrite && !pslverr_q;
    lfc_d = lfc_q;
    mlc_d = mlc_q;
    enh_d = enh_q;
    div_d = div_q;
    tx_byte_d = tx_byte_q;
    tx_start_d = 1'b0;
    if (wr_ok) begin
      case (paddr)
        `OFS_DIV_LOW: if (dlab) div_d[7:0] = pwdata[7:0];
        `OFS_DIV_HIGH: if (dlab) div_d[15:8] = pwdata[7:0];
        `OFS_ENH_FEAT: if (dlab) enh_d = pwdata[7:0];
        `OFS_LINE_FMT: lfc_d = pwdata[7:0];
        `OFS_MODEM_CTL: mlc_d = pwdata[7:0];
        `OFS_TX_DATA: begin
          // a byte written while a character is on the line is dropped
          if (!tx_busy_q) begin
            tx_byte_d = pwdata[7:0];
            tx_start_d = 1'b1;
          end
        end
        default: lfc_d = lfc_q;
      endcase
    end
  end

  // prescaler then divisor; divisor zero behaves as one
  always_comb begin
    pre_d = pre_q + 2'h1;
    pre_tick = mlc_q[`MLC_PRESCALE] ? (pre_q == `PRESCALE_LAST) : 1'b1;
    div_last = (div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001;
    baud_d = baud_q;
    half_tick = 1'b0;
    if (pre_tick) begin
      if (baud_q >= div_last) begin
        baud_d = 16'h0000;
        half_tick = 1'b1;
      end else begin
        baud_d = baud_q + 16'h0001;
      end
    end
  end

  // decoder simplification: an infrared pulse reads as a zero bit, with no
  // pulse-width filter, so a glitch on the infrared input becomes a zero
  always_comb begin
    rx_line_d = mlc_q[`MLC_IR_EN] ? ~ir_rx_in : rx_in;
  end

  // configuration state and the pending transmit byte; the start strobe is
  // a one-cycle pulse so a held write cannot start a second character
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfc_q <= `RST_LINE_FMT;
      mlc_q <= `RST_MODEM_CTL;
      enh_q <= `RST_ENH_FEAT;
      div_q <= `RST_DIV;
      tx_start_q <= 1'b0;
      tx_byte_q <= 8'h00;
    end else begin
      lfc_q <= lfc_d;
      mlc_q <= mlc_d;
      enh_q <= enh_d;
      div_q <= div_d;
      tx_start_q <= tx_start_d;
      tx_byte_q <= tx_byte_d;
    end
  end

  // the answer stands for one cycle only; a master that samples late misses it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // the prescaler free-runs, so the first half tick of a frame has an
  // arbitrary phase and the start bit may be up to one half step short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q <= 2'h0;
      baud_q <= 16'h0000;
    end else begin
      pre_q <= pre_d;
      baud_q <= baud_d;
    end
  end

  // one register stage: the receive path sees the pins a cycle late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_line_q <= 1'b1;
    end else begin
      rx_line_q <= rx_line_d;
    end
  end

  // the serialiser owns the line outputs; each comes straight from one of
  // its flip-flops, so the ports below are plain wires
  char_tx u_tx (
    .clk(clk),
    .rst(rst),
    .half_tick(half_tick),
    .start(tx_start_q),
    .data(tx_byte_q),
    .word_len(lfc_q[`LFC_WLEN_HI:`LFC_WLEN_LO]),
    .stop_sel(lfc_q[`LFC_STOP]),
    .parity_mode(parity_mode),
    .force_break(lfc_q[`LFC_BREAK]),
    .ir_en(mlc_q[`MLC_IR_EN]),
    .tx_out_q(tx_out_w),
    .ir_tx_q(ir_tx_w),
    .busy_q(busy_w)
  );

  assign tx_out_q = tx_out_w;
  assign ir_tx_q = ir_tx_w;
  assign tx_busy_q = busy_w;
endmodule

// *** sim/uart_line_properties.sv ***
/*
  Port-level properties of the line format block.
  Assumes it is bound onto uart_line_format_control: one clock, async reset.
*/
`timescale 1ns/1ps
module uart_line_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q,
  input wire logic rx_in,
  input wire logic ir_rx_in,
  input wire logic tx_out_q,
  input wire logic ir_tx_q,
  input wire logic rx_line_q,
  input wire logic tx_busy_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic ir_mode_q;
  // mirror of the infrared enable, taken from completed modem control writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_mode_q <= 1'b0;
    end else if (pready_q && psel && penable && pwrite && paddr == 12'h010) begin
      ir_mode_q <= pwdata[6];
    end
  end
  sequence s_access;
    psel && penable && !pready_q;
  endsequence
  sequence s_break_wr;
    pready_q && psel && penable && pwrite && paddr == 12'h00c && pwdata[6];
  endsequence
  a_access_ready: assert property (s_access |=> pready_q)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready_q |=> !pready_q)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_q |-> pready_q)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready_q |-> prdata_q == 32'h0)
    else $error("read data outside answer");
  a_rdata_byte: assert property (prdata_q[31:8] == 24'h0)
    else $error("read data above bit 7");
  a_break_holds_low: assert property (s_break_wr |-> ##3 !tx_out_q [*8])
    else $error("break not driving line low");
  a_ir_in_frame: assert property (ir_tx_q |-> ##[0:2] tx_busy_q)
    else $error("infrared pulse outside frame");
  a_rx_route: assert property
    (rx_line_q == ($past(ir_mode_q) ? !$past(ir_rx_in) : $past(rx_in)))
    else $error("receive line not from an input");
endmodule
bind uart_line_format_control uart_line_checker chk (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .rx_in, .ir_rx_in, .tx_out_q,
  .ir_tx_q, .rx_line_q, .tx_busy_q);

// *** sim/serial_peer.sv ***
/*
  Remote serial partner: decodes frames seen on the line, echoes the line back.
  Assumes the bench supplies the format and the half-bit length in clocks.
*/
`timescale 1ns/1ps
module serial_peer (
  input wire logic clk,
  input wire logic line,
  input wire logic ir_line,
  input wire logic [3:0] nbits,
  input wire logic par_on,
  input wire logic [5:0] half,
  output logic rx_in,
  output logic ir_rx_in,
  output logic [7:0] got,
  output logic got_par
);
  int i;
  // echo keeps the receive path busy with real line traffic; the infrared
  // input carries the infrared output, so the two receive sources differ
  always @(posedge clk) begin
    rx_in <= line;
    ir_rx_in <= ir_line;
  end
  // sampling at bit centres tolerates the unknown phase of the first half tick
  always begin
    @(negedge line);
    repeat (3 * half) @(posedge clk);
    got = 8'h00;
    for (i = 0; i < nbits; i++) begin
      got[i] = line;
      repeat (2 * half) @(posedge clk);
    end
    if (par_on) got_par = line;
  end
endmodule

// *** sim/tb_top.sv ***
/*
  Self-checking bench for the line format block: APB master, frames, break.
  Assumes the serial_peer partner and the bound property checker.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata_q, rd, seed = 32'hdc534231;
  logic pready_q, pslverr_q, rx_in, ir_rx_in, tx_out_q, ir_tx_q, rx_line_q, tx_busy_q;
  logic er, got_par, ir_last = 1'b0, par_on = 1'b0;
  logic [7:0] got;
  logic [3:0] nbits = 4'h5;
  logic [5:0] half = 6'h3;
  int num_errors = 0, tests_run = 0, ir_rises = 0, dur, i, h;
  always #12.5 clk = ~clk;
  always @(negedge clk) begin
    if (ir_tx_q === 1'b1 && !ir_last) ir_rises++;
    ir_last = ir_tx_q;
  end
  uart_line_format_control dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_q, .pready_q, .pslverr_q, .rx_in, .ir_rx_in, .tx_out_q, .ir_tx_q, .rx_line_q,
    .tx_busy_q);
  serial_peer peer (.clk, .line(tx_out_q), .ir_line(ir_tx_q), .nbits, .par_on, .half,
    .rx_in, .ir_rx_in, .got, .got_par);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic par_exp(input logic [2:0] p, input logic [7:0] m);
    case (p)
      3'b001: return ~^m;
      3'b011: return ^m;
      3'b101: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one idle edge between transfers so no signal is assigned twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // ready, read data and error are taken at the rising edge that sees ready
    do begin
      @(posedge clk);
      n++;
    end while (pready_q !== 1'b1 && n < 50);
    if (pready_q !== 1'b1) begin
      num_errors++;
      print_verdict;
    end
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] f, input logic [7:0] v, input logic ir);
    logic [7:0] m;
    nbits = 4'h5 + {2'b00, f[1:0]};
    par_on = f[3];
    m = v & ~(8'hff << nbits);
    h = 2 + 2 * nbits + (f[3] ? 2 : 0) + (!f[2] ? 2 : (f[1:0] == 2'b00 ? 3 : 4));
    ir_rises = 0;
    apb(1'b1, 12'h00c, {24'h0, f});
    apb(1'b1, 12'h018, {24'h0, v});
    for (dur = 0; dur < 20 && tx_busy_q !== 1'b1; dur++) @(negedge clk);
    for (dur = 0; dur < 4000 && tx_busy_q === 1'b1; dur++) @(negedge clk);
    if (dur == 4000) begin
      num_errors++;
      print_verdict;
    end
    chk(32'(dur > (h - 1) * half && dur <= h * half + 2), 32'h1);
    if (ir) begin
      chk(ir_rises, 1 + nbits - $countones(m) + (f[3] & ~par_exp(f[5:3], m)));
    end else begin
      chk({24'h0, got}, {24'h0, m});
      if (f[3]) chk(32'(got_par), 32'(par_exp(f[5:3], m)));
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h008, 32'h5a);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h00c, 32'h80);
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h008, 32'h5a);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h5a);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, 12'h01c, 32'h0);
    chk(32'(er), 32'h1);
    // first eight passes walk every parity code and word length
    for (i = 0; i < 20; i++) begin
      seed = lfsr(seed);
      half = seed[16] ? 6'hc : 6'h3;
      apb(1'b1, 12'h010, {24'h0, seed[16], seed[17] & (i > 7), 6'h0});
      if (i < 8) frame({2'b00, i[2:0], i[2] ^ i[0], i[1:0]}, seed[7:0], 1'b0);
      else frame({2'b00, seed[13:8]}, seed[7:0], seed[17]);
    end
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0a);
    apb(1'b1, 12'h00c, 32'h40);
    repeat (30) @(negedge clk);
    chk(32'(tx_out_q), 32'h0);
    apb(1'b1, 12'h00c, 32'h0);
    repeat (4) @(negedge clk);
    chk(32'(tx_out_q), 32'h1);
    print_verdict;
  end
endmodule
